// ### design/hmkrp_packer.sv
`timescale 1ns/1ns
// How it works
// - mouse report starts with identifier byte 1, before the button byte.
// - key report starts with identifier byte 2, before the modifier byte.
// - three-button mode: left, right, middle at bits 0..2; bits 3..7 zero.
// - four-button mode adds back button at bit 3; bits 4..7 zero.
// - 12-bit X: low byte in byte 3, high nibble in byte 4 bits 3..0.
// - 12-bit Y: low nibble in byte 4 bits 7..4, high byte in byte 5.
// - vertical wheel count fills byte 6 of mouse report.
// - with tilt enabled a seventh byte holds horizontal scroll count.
// - modifier byte: right GUI/Alt/Shift/Ctrl then left GUI/Alt/Shift/Ctrl.
// - third key report byte is all zero.
// - first key code in fourth byte of key report.
// - with second key set, second key code in fifth byte.
module hmkrp_packer (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_four_buttons,
	input wire logic i_tilt_enable,
	input wire logic i_second_key_set,
	input wire hmkrp_pkg::hmkrp_buttons_s i_buttons,
	input wire logic i_motion_valid,
	input wire hmkrp_pkg::hmkrp_motion_s i_motion,
	input wire logic i_key_valid,
	input wire hmkrp_pkg::hmkrp_keys_s i_keys,
	output logic o_valid,
	output logic [7:0] o_data,
	output logic o_last,
	input wire logic i_ready
);
	// ==========================================
	// pin synchronisers for configuration straps and buttons
	// straps and buttons are pin levels: two flops before any logic reads them
	logic [6:0] sync1_q;
	logic [6:0] sync2_q;
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= {i_four_buttons, i_tilt_enable, i_second_key_set, i_buttons};
			sync2_q <= sync1_q;
		end
	end
	logic four_buttons;
	logic tilt_en;
	logic second_set;
	hmkrp_pkg::hmkrp_buttons_s buttons;
	assign four_buttons = sync2_q[6];
	assign tilt_en = sync2_q[5];
	assign second_set = sync2_q[4];
	assign buttons = sync2_q[3:0];

	// ==========================================
	// report start, byte counter and last flag
	hmkrp_pkg::hmkrp_state_e state_q;
	logic [2:0] idx_q;
	logic [2:0] len;
	logic beat;
	logic start_mouse;
	logic start_key;
	logic mouse_pend_q;
	logic key_pend_q;
	assign beat = o_valid && i_ready;
	assign o_valid = (state_q != hmkrp_pkg::HMKRP_IDLE);
	// a pending mouse report goes first; the key report waits for an idle cycle with no mouse report pending
	assign start_mouse = (state_q == hmkrp_pkg::HMKRP_IDLE) && mouse_pend_q;
	assign start_key = (state_q == hmkrp_pkg::HMKRP_IDLE) && !mouse_pend_q && key_pend_q;
	// report length follows the straps as seen through the synchronisers
	always_comb begin
		unique case (state_q)
			hmkrp_pkg::HMKRP_MOUSE: len = tilt_en ? hmkrp_pkg::MOUSE_LEN_TILT : hmkrp_pkg::MOUSE_LEN_NO_TILT;
			hmkrp_pkg::HMKRP_KEY: len = second_set ? hmkrp_pkg::KEY_LEN_TWO_SETS : hmkrp_pkg::KEY_LEN_ONE_SET;
			default: len = 3'h1;
		endcase
	end
	assign o_last = o_valid && (idx_q == len - 3'h1);

	// ==========================================
	// accumulators, cleared as their values are copied into a starting report
	logic signed [11:0] acc_x;
	logic signed [11:0] acc_y;
	logic signed [7:0] acc_z;
	logic signed [7:0] acc_t;
	hmkrp_accum #(.WIDTH(12)) u_acc_x (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_add(i_motion_valid),
		.i_delta(i_motion.dx), .i_take(start_mouse), .o_value(acc_x));
	hmkrp_accum #(.WIDTH(12)) u_acc_y (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_add(i_motion_valid),
		.i_delta(i_motion.dy), .i_take(start_mouse), .o_value(acc_y));
	hmkrp_accum #(.WIDTH(8)) u_acc_z (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_add(i_motion_valid),
		.i_delta(i_motion.dz), .i_take(start_mouse), .o_value(acc_z));
	hmkrp_accum #(.WIDTH(8)) u_acc_t (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_add(i_motion_valid),
		.i_delta(i_motion.horizontal_scroll_count), .i_take(start_mouse), .o_value(acc_t));

	// ==========================================
	// report contents frozen at report start, so bytes on offer never change
	// while motion or keys that arrive meanwhile wait for the next report
	hmkrp_pkg::hmkrp_motion_s motion_q;
	hmkrp_pkg::hmkrp_buttons_s sent_buttons_q;
	hmkrp_pkg::hmkrp_keys_s keys_q;
	hmkrp_pkg::hmkrp_keys_s sent_keys_q;

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			motion_q <= '0;
		end else if (start_mouse) begin
			motion_q <= {acc_x, acc_y, acc_z, acc_t};
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sent_buttons_q <= '0;
		end else if (start_mouse) begin
			sent_buttons_q <= buttons;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			keys_q <= '0;
		end else if (i_key_valid) begin
			keys_q <= i_keys;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sent_keys_q <= '0;
		end else if (start_key) begin
			sent_keys_q <= keys_q;
		end
	end

	// ==========================================
	// pending flags: a new event in the start cycle wins over the clear
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mouse_pend_q <= 1'b0;
		end else if (i_motion_valid || (!start_mouse && (buttons != sent_buttons_q))) begin
			mouse_pend_q <= 1'b1;
		end else if (start_mouse) begin
			mouse_pend_q <= 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			key_pend_q <= 1'b0;
		end else if (i_key_valid) begin
			key_pend_q <= 1'b1;
		end else if (start_key) begin
			key_pend_q <= 1'b0;
		end
	end

	// ==========================================
	// report state and byte counter
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= hmkrp_pkg::HMKRP_IDLE;
		end else begin
			unique case (state_q)
				hmkrp_pkg::HMKRP_IDLE: begin
					if (start_mouse) begin
						state_q <= hmkrp_pkg::HMKRP_MOUSE;
					end else if (start_key) begin
						state_q <= hmkrp_pkg::HMKRP_KEY;
					end
				end
				default: begin
					if (beat && o_last) begin
						state_q <= hmkrp_pkg::HMKRP_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			idx_q <= '0;
		end else if (beat) begin
			idx_q <= o_last ? 3'h0 : idx_q + 3'h1;
		end
	end

	// ==========================================
	// byte mux
	logic [7:0] btn_byte;
	always_comb begin
		btn_byte = hmkrp_pkg::BYTE_RESET;
		btn_byte[hmkrp_pkg::LEFT_BUTTON_POS] = sent_buttons_q.left_button;
		btn_byte[hmkrp_pkg::RIGHT_BUTTON_POS] = sent_buttons_q.right_button;
		btn_byte[hmkrp_pkg::MIDDLE_BUTTON_POS] = sent_buttons_q.middle_button;
		btn_byte[hmkrp_pkg::BACK_BUTTON_POS] = four_buttons && sent_buttons_q.back_button;
	end

	// idle and unused byte slots read as zero
	always_comb begin
		o_data = hmkrp_pkg::BYTE_RESET;
		if (state_q == hmkrp_pkg::HMKRP_MOUSE) begin
			unique case (idx_q)
				3'h0: o_data = hmkrp_pkg::MOUSE_REPORT_ID;
				3'h1: o_data = btn_byte;
				3'h2: o_data = motion_q.dx[7:0];
				3'h3: o_data = {motion_q.dy[3:0], motion_q.dx[11:8]};
				3'h4: o_data = motion_q.dy[11:4];
				3'h5: o_data = motion_q.dz;
				hmkrp_pkg::LAST_BYTE_IDX: o_data = motion_q.horizontal_scroll_count;
				default: o_data = hmkrp_pkg::BYTE_RESET;
			endcase
		end else if (state_q == hmkrp_pkg::HMKRP_KEY) begin
			unique case (idx_q)
				3'h0: o_data = hmkrp_pkg::KEY_REPORT_ID;
				3'h1: o_data = sent_keys_q.modifiers;
				3'h2: o_data = hmkrp_pkg::RESERVED_BYTE;
				3'h3: o_data = sent_keys_q.first_key_set;
				3'h4: o_data = sent_keys_q.second_key_set;
				default: o_data = hmkrp_pkg::BYTE_RESET;
			endcase
		end
	end
endmodule

// ### design/hmkrp_pkg.sv
package hmkrp_pkg;
	// ==========================================
	// report identifiers and lengths
	localparam logic [7:0] MOUSE_REPORT_ID = 8'h01;
	localparam logic [7:0] KEY_REPORT_ID = 8'h02;
	localparam logic [2:0] MOUSE_LEN_NO_TILT = 3'h6;
	localparam logic [2:0] MOUSE_LEN_TILT = 3'h7;
	localparam logic [2:0] KEY_LEN_ONE_SET = 3'h4;
	localparam logic [2:0] KEY_LEN_TWO_SETS = 3'h5;
	localparam logic [2:0] LAST_BYTE_IDX = 3'h6;
	// ==========================================
	// field positions in the mouse button byte
	localparam int LEFT_BUTTON_POS = 0;
	localparam int RIGHT_BUTTON_POS = 1;
	localparam int MIDDLE_BUTTON_POS = 2;
	localparam int BACK_BUTTON_POS = 3;
	// ==========================================
	// reset values
	localparam logic [11:0] MOTION_RESET = 12'h000;
	localparam logic [7:0] WHEEL_RESET = 8'h00;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [7:0] RESERVED_BYTE = 8'h00;

	typedef enum logic [1:0] {
		HMKRP_IDLE = 2'b00,
		HMKRP_MOUSE = 2'b01,
		HMKRP_KEY = 2'b10
	} hmkrp_state_e;

	typedef struct packed {
		logic left_button;
		logic right_button;
		logic middle_button;
		logic back_button;
	} hmkrp_buttons_s;

	typedef struct packed {
		logic [11:0] dx;
		logic [11:0] dy;
		logic [7:0] dz;
		logic [7:0] horizontal_scroll_count;
	} hmkrp_motion_s;

	typedef struct packed {
		logic [7:0] modifiers;
		logic [7:0] first_key_set;
		logic [7:0] second_key_set;
	} hmkrp_keys_s;
endpackage

// ### design/hmkrp_accum.sv
`timescale 1ns/1ns
// saturating signed accumulator, cleared when its value is taken
module hmkrp_accum #(
	parameter int WIDTH = 12
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_add,
	input wire logic signed [WIDTH-1:0] i_delta,
	input wire logic i_take,
	output logic signed [WIDTH-1:0] o_value
);
	localparam logic signed [WIDTH:0] MAXV = (WIDTH+1)'((1 << (WIDTH-1)) - 1);
	localparam logic signed [WIDTH:0] MINV = -MAXV - (WIDTH+1)'(1);

	logic signed [WIDTH:0] sum;
	logic signed [WIDTH-1:0] base;

	// a delta landing in the take cycle starts the next report
	always_comb begin
		base = i_take ? '0 : o_value;
		sum = {base[WIDTH-1], base} + {i_delta[WIDTH-1], i_delta};
		if (!i_add) begin
			sum = {base[WIDTH-1], base};
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_value <= '0;
		end else if (sum > MAXV) begin
			o_value <= MAXV[WIDTH-1:0];
		end else if (sum < MINV) begin
			o_value <= MINV[WIDTH-1:0];
		end else begin
			o_value <= sum[WIDTH-1:0];
		end
	end
endmodule

// ### sim/hmkrp_props.sv
`timescale 1ns/1ns
module hmkrp_props (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_four_buttons,
	input wire logic i_tilt_enable,
	input wire logic i_second_key_set,
	input wire logic o_valid,
	input wire logic [7:0] o_data,
	input wire logic o_last,
	input wire logic i_ready
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	logic [2:0] idx_q;
	logic mouse_q;
	logic [2:0] last_idx;
	assign last_idx = mouse_q ? (i_tilt_enable ? 3'h6 : 3'h5) : (i_second_key_set ? 3'h4 : 3'h3);
	// byte position within the report on offer
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			idx_q <= 3'h0;
			mouse_q <= 1'b0;
		end else if (o_valid && i_ready) begin
			idx_q <= o_last ? 3'h0 : idx_q + 3'h1;
			if (idx_q == 3'h0) mouse_q <= (o_data == hmkrp_pkg::MOUSE_REPORT_ID);
		end
	end
	sequence beat_s;
		o_valid && i_ready;
	endsequence
	id_byte_a: assert property (o_valid && idx_q == 3'h0 |-> o_data inside {8'h01, 8'h02})
		else $error("bad report id");
	hold_offer_a: assert property (o_valid && !i_ready |=> o_valid && $stable(o_data))
		else $error("offer dropped");
	three_pad_a: assert property (o_valid && mouse_q && idx_q == 3'h1 && !i_four_buttons |-> o_data[7:3] == 5'h00)
		else $error("button pad set");
	four_pad_a: assert property (o_valid && mouse_q && idx_q == 3'h1 && i_four_buttons |-> o_data[7:4] == 4'h0)
		else $error("button pad set");
	key_zero_a: assert property (o_valid && !mouse_q && idx_q == 3'h2 |-> o_data == 8'h00)
		else $error("key pad set");
	report_len_a: assert property (o_valid && o_last |-> idx_q == last_idx)
		else $error("wrong length");
	idle_gap_a: assert property (beat_s ##0 o_last |=> !o_valid)
		else $error("no idle gap");
	last_flag_a: assert property (o_valid && idx_q == last_idx |-> o_last)
		else $error("last flag missing");
endmodule
bind hmkrp_packer hmkrp_props u_props (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_four_buttons(i_four_buttons),
	.i_tilt_enable(i_tilt_enable), .i_second_key_set(i_second_key_set), .o_valid(o_valid), .o_data(o_data),
	.o_last(o_last), .i_ready(i_ready));

// ### sim/hmkrp_host.sv
`timescale 1ns/1ns
module hmkrp_host (
	input wire logic i_sys_clk,
	input wire logic i_slow,
	input wire logic i_valid,
	input wire logic [7:0] i_data,
	output logic o_ready
);
	logic [7:0] rx_q[$];
	initial o_ready = 1'b0;
	// polls every cycle, or every other cycle when slow
	always @(negedge i_sys_clk) begin
		o_ready <= !i_slow || !o_ready;
	end
	always @(posedge i_sys_clk) begin
		if (i_valid && o_ready) rx_q.push_back(i_data);
	end
endmodule

// ### sim/testbench.sv
`timescale 1ns/1ns
module testbench;
	logic clk = 0, rst_n = 0, four = 0, tilt = 0, two = 0, mv = 0, kv = 0, slow = 0;
	hmkrp_pkg::hmkrp_buttons_s btn = '0;
	hmkrp_pkg::hmkrp_motion_s mot = '0;
	hmkrp_pkg::hmkrp_keys_s keys = '0;
	logic valid, last, ready;
	logic [7:0] data;
	logic [31:0] r = 32'h5b3e4cac;
	logic [7:0] exp_q[$];
	int miscompares = 0, compares = 0;
	always #5 clk = ~clk;
	hmkrp_packer dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_four_buttons(four), .i_tilt_enable(tilt),
		.i_second_key_set(two), .i_buttons(btn), .i_motion_valid(mv), .i_motion(mot), .i_key_valid(kv),
		.i_keys(keys), .o_valid(valid), .o_data(data), .o_last(last), .i_ready(ready));
	hmkrp_host host (.i_sys_clk(clk), .i_slow(slow), .i_valid(valid), .i_data(data), .o_ready(ready));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic summarize;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// one or two equal deltas summed and held within the w-bit signed range
	function automatic logic [11:0] acc_exp(input logic [11:0] d, input int w, input bit twice);
		int v;
		int lim;
		lim = 1 << (w - 1);
		v = (w == 12) ? int'($signed(d)) : int'($signed(d[7:0]));
		if (twice) v = v * 2;
		if (v > lim - 1) v = lim - 1;
		if (v < -lim) v = -lim;
		return 12'(v);
	endfunction
	function automatic void mouse_exp(input bit twice);
		logic [11:0] x;
		logic [11:0] y;
		logic [11:0] z;
		logic [11:0] t;
		x = acc_exp(mot.dx, 12, twice);
		y = acc_exp(mot.dy, 12, twice);
		z = acc_exp({4'h0, mot.dz}, 8, twice);
		t = acc_exp({4'h0, mot.horizontal_scroll_count}, 8, twice);
		exp_q.push_back(hmkrp_pkg::MOUSE_REPORT_ID);
		exp_q.push_back({4'h0, btn.back_button & four, btn.middle_button, btn.right_button, btn.left_button});
		exp_q.push_back(x[7:0]);
		exp_q.push_back({y[3:0], x[11:8]});
		exp_q.push_back(y[11:4]);
		exp_q.push_back(z[7:0]);
		if (tilt) exp_q.push_back(t[7:0]);
	endfunction
	function automatic void key_exp();
		exp_q.push_back(hmkrp_pkg::KEY_REPORT_ID);
		exp_q.push_back(keys.modifiers);
		exp_q.push_back(8'h00);
		exp_q.push_back(keys.first_key_set);
		if (two) exp_q.push_back(keys.second_key_set);
	endfunction
	// a button change sends its own report, which is let through here
	task automatic set_btn;
		r = lfsr(r);
		btn = r[3:0];
		repeat (30) @(negedge clk);
	endtask
	task automatic run(input bit m, input bit k, input bit twice, input logic [39:0] mval);
		int n;
		r = lfsr(r);
		mot = mval;
		keys = r[23:0];
		exp_q.delete();
		if (m) mouse_exp(1'b0);
		if (m && twice) mouse_exp(1'b1);
		if (k) key_exp();
		host.rx_q.delete();
		@(negedge clk);
		mv = m;
		kv = k;
		@(negedge clk);
		mv = 0;
		kv = 0;
		// two more deltas land while the first report is on offer and add up for the next one
		@(negedge clk);
		mv = m && twice;
		repeat (2) @(negedge clk);
		mv = 0;
		n = 0;
		while (host.rx_q.size() < exp_q.size() && n < 200) begin
			@(negedge clk);
			n++;
		end
		check("byte count", 8'(host.rx_q.size()), 8'(exp_q.size()));
		foreach (exp_q[i]) check("report byte", host.rx_q[i], exp_q[i]);
	endtask
	initial begin
		for (int c = 0; c < 8; c++) begin
			rst_n = 0;
			{four, tilt, two} = c[2:0];
			slow = c[0] ^ c[1];
			repeat (6) @(negedge clk);
			rst_n = 1;
			// buttons left from the previous pass send their own report after reset
			repeat (30) @(negedge clk);
			run(1, 1, 1, 40'h800_7ff_80_7f);
			for (int i = 0; i < 6; i++) begin
				set_btn();
				r = lfsr(r);
				run(i[0], !i[0] || i[1], i[2], {r, r[7:0] ^ r[15:8]});
			end
		end
		summarize();
	end
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		summarize();
	end
endmodule
